/* File: shared/pc_stack_pkg.sv */
// Constants and types for the program-flow and indirect-address unit
package pc_stack_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W        = 13;
  localparam int JUMP_W      = 11;
  localparam int DATA_W      = 8;
  localparam int IND_ADDR_W  = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int OP_W        = 3;

  // ==========================================================================
  // Field positions within the high-byte latch
  localparam int LATCH_UPPER_MSB = 4;
  localparam int LATCH_PAGE_LSB  = 3;

  // ==========================================================================
  // Reset values and fixed addresses
  localparam logic [PC_W-1:0]   PC_RESET_VALUE  = 13'h0000;
  localparam logic [PC_W-1:0]   INT_VECTOR_ADDR = 13'h0004;
  localparam logic [DATA_W-1:0] LATCH_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] POINTER_RESET   = 8'h00;
  localparam logic [SP_W-1:0]   SP_RESET        = 3'h0;
  localparam logic [DATA_W-1:0] IND_READ_SELF   = 8'h00;

  // ==========================================================================
  // File addresses decoded by the unit (low seven bits of a file address)
  localparam logic [6:0] ADDR_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] ADDR_PC_LOW        = 7'h02;
  localparam logic [6:0] ADDR_POINTER       = 7'h04;
  localparam logic [6:0] ADDR_HIGH_LATCH    = 7'h0a;

  // ==========================================================================
  // Flow operations issued by the decoder, one per cycle
  typedef enum logic [OP_W-1:0] {
    FLOW_STEP   = 3'b000,
    FLOW_JUMP   = 3'b001,
    FLOW_CALL   = 3'b010,
    FLOW_RETURN = 3'b011,
    FLOW_INTR   = 3'b100,
    FLOW_HOLD   = 3'b101
  } flow_op_t;

endpackage : pc_stack_pkg

/* File: design/return_stack.sv */
// Eight-entry circular return stack with a hidden wrapping pointer
module return_stack
  import pc_stack_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       push,
  input  wire logic                       pop,
  input  wire logic [pc_stack_pkg::PC_W-1:0] push_data,
  output logic      [pc_stack_pkg::PC_W-1:0] top_data
);

  logic [PC_W-1:0] entry_reg [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;

  // ==========================================================================
  // Pointer wraps modulo eight both ways; no overflow or underflow flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_reg <= SP_RESET;
    end else if (push) begin
      sp_reg <= sp_reg + 3'h1; // RQ11 RQ12
    end else if (pop) begin
      sp_reg <= sp_reg - 3'h1; // RQ21
    end
  end

  // Storage is not reset: entries are unknown until written
  always_ff @(posedge clk) begin
    if (push) begin
      entry_reg[sp_reg] <= push_data; // RQ7
    end
  end

  // Top of stack is the slot just below the pointer
  assign top_data = entry_reg[sp_reg - 3'h1];

endmodule // return_stack

/* File: design/pc_flow_unit.sv */
// Program counter, paging latch, return stack control and indirect addressing
// Function
// RQ1 - Keep 13-bit PC, low byte readable/writable
// RQ2 - Upper PC bits only from high latch
// RQ3 - Any reset clears PC to zero
// RQ4 - Low-byte write loads latch bits 4:0 upward
// RQ5 - Call/jump: 11 instruction bits, latch bits 4:3
// RQ6 - Software keeps computed tables within 256 blocks
// RQ7 - Eight-entry 13-bit stack, hidden pointer
// RQ8 - Push PC on call and interrupt
// RQ9 - Pop PC on all return kinds
// RQ10 - Push and pop leave latch unchanged
// RQ11 - Stack wraps circularly, ninth push overwrites first
// RQ12 - No overflow or underflow status
// RQ13 - Return restores all 13 PC bits
// RQ14 - 8K program space, 2K call pages
// RQ15 - Software sets page bits before call/jump
// RQ16 - Indirect port accesses pointer-selected location
// RQ17 - Indirect read of itself returns 00h
// RQ18 - Indirect write of itself stores nothing
// RQ19 - Indirect address is bank bit plus pointer
// RQ20 - Interrupt loads vector 0004h after push
// RQ21 - Pointer wraps both ways, stale pop allowed
module pc_flow_unit
  import pc_stack_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire pc_stack_pkg::flow_op_t              flow_op,
  input  wire logic [pc_stack_pkg::JUMP_W-1:0]     jump_target,
  input  wire logic                                indirect_bank_bit,
  input  wire logic [8:0]                          file_addr,
  input  wire logic [pc_stack_pkg::DATA_W-1:0]     file_wdata,
  input  wire logic                                file_wr,
  input  wire logic                                file_rd,
  input  wire logic [pc_stack_pkg::DATA_W-1:0]     mem_rdata,
  output logic      [pc_stack_pkg::PC_W-1:0]       pc_out,
  output logic      [pc_stack_pkg::DATA_W-1:0]     file_rdata,
  output logic      [pc_stack_pkg::IND_ADDR_W-1:0] mem_addr,
  output logic      [pc_stack_pkg::DATA_W-1:0]     mem_wdata,
  output logic                                     mem_wr,
  output logic                                     mem_rd
);

  import pc_stack_pkg::*;

  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   pc_next;
  logic [DATA_W-1:0] pc_high_latch;
  logic [DATA_W-1:0] file_select_pointer;
  logic [PC_W-1:0]   stack_top;
  logic              stack_push;
  logic              stack_pop;
  logic              pc_low_write;
  logic              ind_sel;
  logic              ind_self;
  logic [IND_ADDR_W-1:0] ind_addr;
  logic              own_rd_pending_reg;
  logic [DATA_W-1:0] own_rdata_reg;
  logic              mem_rd_pending_reg;

  // ==========================================================================
  // Address decoding shared by read and write paths
  function automatic logic hits(input logic [8:0] addr, input logic [6:0] off);
    hits = (addr[6:0] == off);
  endfunction

  assign ind_sel      = hits(file_addr, ADDR_INDIRECT_PORT); // RQ16
  assign ind_addr     = {indirect_bank_bit, file_select_pointer}; // RQ19
  assign ind_self     = hits({1'b0, ind_addr[7:0]}, ADDR_INDIRECT_PORT);
  assign pc_low_write = file_wr && !ind_sel && hits(file_addr, ADDR_PC_LOW);

  // ==========================================================================
  // Stack control
  assign stack_push = (flow_op == FLOW_CALL) || (flow_op == FLOW_INTR); // RQ8
  assign stack_pop  = (flow_op == FLOW_RETURN); // RQ9

  return_stack u_stack (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (pc_next_step()),
    .top_data  (stack_top)
  );

  // Return address is the instruction after the current one
  function automatic logic [PC_W-1:0] pc_next_step();
    pc_next_step = pc_reg + 13'h0001; // RQ14
  endfunction

  // ==========================================================================
  // Program counter next value
  always_comb begin
    pc_next = pc_next_step();
    if (pc_low_write) begin
      // Computed jumps take the whole upper field from the latch
      pc_next = {pc_high_latch[LATCH_UPPER_MSB:0], file_wdata}; // RQ4
    end else begin
      unique case (flow_op)
        FLOW_STEP:   pc_next = pc_next_step();
        FLOW_JUMP,
        FLOW_CALL:   pc_next = {pc_high_latch[LATCH_UPPER_MSB:LATCH_PAGE_LSB],
                                jump_target}; // RQ5
        FLOW_RETURN: pc_next = stack_top; // RQ13
        FLOW_INTR:   pc_next = INT_VECTOR_ADDR; // RQ20
        FLOW_HOLD:   pc_next = pc_reg;
        default:     pc_next = pc_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_reg <= PC_RESET_VALUE; // RQ3
    end else begin
      pc_reg <= pc_next; // RQ1
    end
  end

  assign pc_out = pc_reg;

  // ==========================================================================
  // High latch: only reset and software writes change it, never stack traffic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_high_latch <= LATCH_RESET;
    end else if (file_wr && !ind_sel && hits(file_addr, ADDR_HIGH_LATCH)) begin
      pc_high_latch <= file_wdata; // RQ10
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_select_pointer <= POINTER_RESET;
    end else if (file_wr && !ind_sel && hits(file_addr, ADDR_POINTER)) begin
      file_select_pointer <= file_wdata;
    end
  end

  // ==========================================================================
  // Indirect data port toward data memory
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_addr  <= '0;
      mem_wdata <= '0;
      mem_wr    <= 1'b0;
      mem_rd    <= 1'b0;
    end else begin
      mem_addr  <= ind_addr;
      mem_wdata <= file_wdata;
      mem_wr    <= file_wr && ind_sel && !ind_self; // RQ18
      mem_rd    <= file_rd && ind_sel && !ind_self;
    end
  end

  // ==========================================================================
  // Read data: registers one cycle after the read strobe, indirect memory reads two cycles after
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      own_rd_pending_reg <= 1'b0;
      mem_rd_pending_reg <= 1'b0;
      own_rdata_reg      <= '0;
    end else begin
      own_rd_pending_reg <= file_rd;
      mem_rd_pending_reg <= mem_rd;
      if (file_rd) begin
        if (ind_sel) begin
          own_rdata_reg <= IND_READ_SELF; // RQ17
        end else if (hits(file_addr, ADDR_PC_LOW)) begin
          own_rdata_reg <= pc_reg[DATA_W-1:0]; // RQ1 RQ2
        end else if (hits(file_addr, ADDR_HIGH_LATCH)) begin
          own_rdata_reg <= pc_high_latch;
        end else if (hits(file_addr, ADDR_POINTER)) begin
          own_rdata_reg <= file_select_pointer;
        end else begin
          own_rdata_reg <= '0;
        end
      end
    end
  end

  // Memory answers indirect reads in the cycle after the memory strobe
  always_comb begin
    file_rdata = own_rd_pending_reg ? own_rdata_reg : '0;
    if (mem_rd_pending_reg) begin
      file_rdata = mem_rdata;
    end
  end

  // ==========================================================================
  // Checks
  chk_reset_pc_zero: assert property (@(posedge clk)
    sys_rst |=> pc_reg == PC_RESET_VALUE) else $error("PC not cleared by reset"); // RQ3
  chk_low_write_load: assert property (@(posedge clk) disable iff (sys_rst)
    pc_low_write |=> pc_reg == {$past(pc_high_latch[4:0]), $past(file_wdata)})
    else $error("Low byte write load wrong"); // RQ4
  chk_jump_page: assert property (@(posedge clk) disable iff (sys_rst)
    (flow_op inside {FLOW_JUMP, FLOW_CALL}) && !pc_low_write
    |=> pc_reg == {$past(pc_high_latch[4:3]), $past(jump_target)})
    else $error("Jump target paging wrong"); // RQ5
  chk_intr_vector: assert property (@(posedge clk) disable iff (sys_rst)
    flow_op == FLOW_INTR && !pc_low_write |=> pc_reg == INT_VECTOR_ADDR)
    else $error("Interrupt vector not loaded"); // RQ20
  chk_call_return: assert property (@(posedge clk) disable iff (sys_rst)
    flow_op == FLOW_CALL && !pc_low_write ##1 flow_op == FLOW_RETURN && !pc_low_write
    && !$past(sys_rst) |=> pc_reg == $past(pc_reg, 2) + 13'h0001)
    else $error("Return address not restored"); // RQ13
  chk_latch_kept: assert property (@(posedge clk) disable iff (sys_rst)
    (stack_push || stack_pop) && !file_wr |=> $stable(pc_high_latch))
    else $error("Latch changed by stack op"); // RQ10
  chk_self_no_write: assert property (@(posedge clk) disable iff (sys_rst)
    file_wr && ind_sel && ind_self |=> !mem_wr) else $error("Self write reached memory"); // RQ18
  chk_self_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    file_rd && ind_sel && ind_self |=> file_rdata == IND_READ_SELF)
    else $error("Self read not zero"); // RQ17
  chk_ind_address: assert property (@(posedge clk) disable iff (sys_rst)
    file_wr && ind_sel && !ind_self |=> mem_wr && mem_addr == $past(ind_addr))
    else $error("Indirect address wrong"); // RQ19

  cov_call: cover property (@(posedge clk) disable iff (sys_rst) flow_op == FLOW_CALL);
  cov_return: cover property (@(posedge clk) disable iff (sys_rst)
    flow_op == FLOW_CALL ##1 flow_op == FLOW_RETURN);
  cov_intr: cover property (@(posedge clk) disable iff (sys_rst) flow_op == FLOW_INTR);
  cov_ind_rd: cover property (@(posedge clk) disable iff (sys_rst) mem_rd);

endmodule // pc_flow_unit

/* File: dv/data_mem_model.sv */
// Data memory model answering the unit's indirect accesses
module data_mem_model (
  input  wire logic       clk,
  input  wire logic [8:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic       mem_wr,
  input  wire logic       mem_rd,
  output logic      [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
  logic [7:0] last = 8'h5a;
  logic       rd_q = 1'b0;
  // =====================================================
  // Storage; data valid only in the cycle after a read
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last <= mem[mem_addr];
    rd_q <= mem_rd;
  end
  // Outside the answer cycle show the inverse, never a held value
  assign mem_rdata = rd_q ? last : ~last;
endmodule // data_mem_model

/* File: dv/tb_pc_stack_indirect_addressing.sv */
// Self-checking bench for the program-flow and indirect-address unit
module tb_pc_stack_indirect_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  import pc_stack_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, ind_bank = 1'b0, file_wr = 1'b0, file_rd = 1'b0;
  flow_op_t    flow_op = FLOW_HOLD;
  logic [10:0] jump_target = 11'h000;
  logic [8:0]  file_addr = 9'h000, mem_addr;
  logic [7:0]  file_wdata = 8'h00, file_rdata, mem_rdata, mem_wdata;
  logic [12:0] pc_out;
  logic        mem_wr, mem_rd;
  int          n_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  pc_flow_unit pc_flow_unit_i (.clk(clk), .sys_rst(sys_rst), .flow_op(flow_op),
    .jump_target(jump_target), .indirect_bank_bit(ind_bank), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_wr(file_wr), .file_rd(file_rd), .mem_rdata(mem_rdata),
    .pc_out(pc_out), .file_rdata(file_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd));
  data_mem_model data_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  // =====================================================
  // Shared tasks
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task ck(input logic [12:0] got, input logic [12:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One cycle of request; upper address bits set to show the bank mirror
  task op(input flow_op_t f, input logic [10:0] t, input logic w, input logic r,
          input logic [6:0] a, input logic [7:0] d);
    flow_op <= f;
    jump_target <= t;
    file_wr <= w;
    file_rd <= r;
    file_addr <= {2'b01, a};
    file_wdata <= d;
    @(posedge clk);
  endtask
  // Requests stand until the next request or idle replaces them
  task idle;
    flow_op <= FLOW_HOLD;
    file_wr <= 1'b0;
    file_rd <= 1'b0;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    op(FLOW_HOLD, 11'h000, 1'b1, 1'b0, a, d);
  endtask
  task fl(input flow_op_t f, input logic [10:0] t);
    op(f, t, 1'b0, 1'b0, 7'h7f, 8'h00);
  endtask
  task rd_ck(input logic [6:0] a, input logic [7:0] e, input int lat, input string m);
    op(FLOW_HOLD, 11'h000, 1'b0, 1'b1, a, 8'h00);
    idle;
    repeat (lat - 1) @(posedge clk);
    @(negedge clk);
    ck(file_rdata, e, m);
    @(posedge clk);
  endtask
  task pc_ck(input logic [12:0] e, input string m);
    idle;
    @(negedge clk);
    ck(pc_out, e, m);
    @(posedge clk);
  endtask
  // =====================================================
  // Scenarios
  task t_reset;
    pc_ck(13'h0000, "pc after reset");
    fl(FLOW_STEP, 11'h000);
    fl(FLOW_STEP, 11'h000);
    pc_ck(13'h0002, "pc step");
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    pc_ck(13'h0000, "pc after second reset");
    $display("reset test done");
  endtask
  task t_paging;
    wr(ADDR_HIGH_LATCH, 8'h1d);
    rd_ck(ADDR_HIGH_LATCH, 8'h1d, 1, "latch read");
    wr(ADDR_PC_LOW, 8'h34);
    pc_ck(13'h1d34, "low byte write");
    rd_ck(ADDR_PC_LOW, 8'h34, 1, "low byte read");
    fl(FLOW_JUMP, 11'h7f0);
    pc_ck(13'h1ff0, "jump page 3");
    wr(ADDR_HIGH_LATCH, 8'h08);
    fl(FLOW_JUMP, 11'h123);
    pc_ck(13'h0923, "jump page 1");
    $display("paging test done");
  endtask
  // Nine calls wrap the eight slots; pops then come back round silently
  task t_stack;
    wr(ADDR_HIGH_LATCH, 8'h00);
    fl(FLOW_JUMP, 11'h000);
    for (int i = 0; i < 9; i++) fl(FLOW_CALL, 11'h100 + 11'(i));
    pc_ck(13'h0108, "last call");
    wr(ADDR_HIGH_LATCH, 8'h18);
    for (int k = 0; k < 9; k++) begin
      fl(FLOW_RETURN, 11'h000);
      pc_ck((k == 8) ? 13'h0108 : 13'h0108 - 13'(k), "return");
    end
    rd_ck(ADDR_HIGH_LATCH, 8'h18, 1, "latch after pops");
    $display("stack test done");
  endtask
  task t_intr;
    fl(FLOW_JUMP, 11'h055);
    fl(FLOW_INTR, 11'h000);
    pc_ck(13'h0004, "interrupt vector");
    fl(FLOW_RETURN, 11'h000);
    pc_ck(13'h1856, "interrupt return");
    fl(FLOW_CALL, 11'h200);
    fl(FLOW_RETURN, 11'h000);
    pc_ck(13'h1857, "call then return");
    rd_ck(ADDR_HIGH_LATCH, 8'h18, 1, "latch after interrupt");
    $display("interrupt test done");
  endtask
  task t_indirect;
    wr(ADDR_POINTER, 8'h25);
    for (int b = 0; b < 2; b++) begin
      ind_bank <= 1'(b);
      wr(ADDR_INDIRECT_PORT, 8'h30 + 8'(b));
      idle;
      @(negedge clk);
      ck(13'(mem_wr), 13'h0001, "indirect write strobe");
      ck(13'(mem_addr), {4'h0, 1'(b), 8'h25}, "indirect address");
      ck(13'(mem_wdata), 13'h0030 + 13'(b), "indirect data");
      @(posedge clk);
    end
    for (int b = 0; b < 2; b++) begin
      ind_bank <= 1'(b);
      rd_ck(ADDR_INDIRECT_PORT, 8'h30 + 8'(b), 2, "indirect read");
    end
    wr(ADDR_POINTER, 8'h00);
    wr(ADDR_INDIRECT_PORT, 8'hff);
    idle;
    @(negedge clk);
    ck(13'(mem_wr), 13'h0000, "self write stored");
    @(posedge clk);
    rd_ck(ADDR_INDIRECT_PORT, 8'h00, 1, "self read");
    rd_ck(ADDR_INDIRECT_PORT, 8'h00, 2, "self read no memory");
    $display("indirect test done");
  endtask
  // =====================================================
  // Main sequence and hang guard
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_paging;
    t_stack;
    t_intr;
    t_indirect;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule // tb_pc_stack_indirect_addressing
